// file: hdl/wrap_hybrid_burst_pkg.sv
package wrap_hybrid_burst_pkg;
  localparam int ADDR_W = 32;
  localparam int CA_W = 48;
  localparam int BURST_TYPE_POS = 45;
  localparam int CA_ROW_HI = 44;
  localparam int CA_ROW_LO = 16;
  localparam int CA_COL_HI = 2;
  localparam int CFG_W = 3;
  localparam int HYBRID_POS = 2;
  localparam int OFS_W = 6;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h7;
  localparam logic [1:0] LEN_128 = 2'h0;
  localparam logic [1:0] LEN_64 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h2;
  localparam logic [1:0] LEN_32 = 2'h3;
  localparam logic [OFS_W-1:0] MASK_128 = 6'h3f;
  localparam logic [OFS_W-1:0] MASK_64 = 6'h1f;
  localparam logic [OFS_W-1:0] MASK_16 = 6'h07;
  localparam logic [OFS_W-1:0] MASK_32 = 6'h0f;
  typedef enum logic [1:0] {
    MODE_LINEAR = 2'b00,
    MODE_LEGACY = 2'b01,
    MODE_HYBRID = 2'b10
  } burst_mode_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } seq_state_t;
endpackage : wrap_hybrid_burst_pkg

// file: hdl/wrap_hybrid_burst_sequencer.sv
// How it works
// - A hybrid burst first visits every word of the aligned group holding the start, wrapping to the base.
// - After that single wrap pass it jumps to the base of the next aligned group.
// - From there it counts up linearly while chip select stays low; chip select high ends it.
// - Hybrid-select at 0 makes wrapped-type bursts run the hybrid sequence.
// - Hybrid-select at 1 makes wrapped bursts wrap forever, and 1 is its reset value.
// - Burst type 0 with setting 000 is a hybrid burst over a 64-word (128-byte) group.
// - Settings 001 and 101 use a 32-word (64-byte) group.
// - Settings 010 and 110 use an 8-word (16-byte) group.
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + PW'(1);
      end
      if (pop)
      begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + PW'(1);
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  a_fifo_bounds: assert property (@(posedge ref_clk) disable iff (rst) count_q <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");

  a_fifo_flush_empty: assert property (@(posedge ref_clk) disable iff (rst) flush |=> !outValid)
    else $error("fifo not empty after flush");
endmodule : sync_fifo

module wrap_hybrid_burst_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic caStrobe,
  input wire logic [wrap_hybrid_burst_pkg::CA_W-1:0] commandAddressWord,
  input wire logic cfgWrite,
  input wire logic [wrap_hybrid_burst_pkg::CFG_W-1:0] cfgData,
  output logic [wrap_hybrid_burst_pkg::CFG_W-1:0] burstConfig,
  output logic busy,
  output logic arrayValid,
  input wire logic arrayReady,
  output logic [wrap_hybrid_burst_pkg::ADDR_W-1:0] arrayAddr
);
  import wrap_hybrid_burst_pkg::*;

  logic linkRstS1_q;
  logic linkRstS2_q;
  logic [CA_W-1:0] cmdWord_q;
  logic cmdTog_q;
  logic cmdSync1_q;
  logic cmdSync2_q;
  logic cmdSeen_q;
  logic csSync1_q;
  logic csSync2_q;
  logic [CFG_W-1:0] burstConfig_q;
  seq_state_t state_q;
  burst_mode_t mode_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] grpBase_q;
  logic [OFS_W-1:0] wrapCnt_q;
  logic [OFS_W-1:0] mask;
  logic [OFS_W-1:0] mask_q;
  logic [ADDR_W-1:0] maskWide;
  logic [ADDR_W-1:0] wrapNext;
  logic [ADDR_W-1:0] startAddr;
  logic newCmd;
  logic csLow;
  logic fifoInReady;
  logic fifoInValid;
  logic push;
  logic lastWrap;

  // Link side: reset follows rst, command held stable for the other domain
  always_ff @(posedge linkClk)
  begin
    linkRstS1_q <= rst;
    linkRstS2_q <= linkRstS1_q;
  end

  always_ff @(posedge linkClk)
  begin
    if (linkRstS2_q)
    begin
      cmdWord_q <= '0;
      cmdTog_q <= 1'b0;
    end
    else if (caStrobe && !csN)
    begin
      cmdWord_q <= commandAddressWord;
      cmdTog_q <= !cmdTog_q;
    end
  end

  // Crossings into ref_clk: toggle for the command, level for chip select
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmdSync1_q <= 1'b0;
      cmdSync2_q <= 1'b0;
      cmdSeen_q <= 1'b0;
      csSync1_q <= 1'b1;
      csSync2_q <= 1'b1;
    end
    else
    begin
      cmdSync1_q <= cmdTog_q;
      cmdSync2_q <= cmdSync1_q;
      cmdSeen_q <= cmdSync2_q;
      csSync1_q <= csN;
      csSync2_q <= csSync1_q;
    end
  end

  // A command arriving while busy is dropped, not queued
  assign newCmd = cmdSync2_q ^ cmdSeen_q;
  assign csLow = !csSync2_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      burstConfig_q <= CFG_RESET;
    end
    else if (cfgWrite && state_q == ST_IDLE)
    begin
      burstConfig_q <= cfgData;
    end
  end

  assign burstConfig = burstConfig_q;

  always_comb
  begin
    case (burstConfig_q[1:0])
      LEN_128: mask = MASK_128;
      LEN_64: mask = MASK_64;
      LEN_16: mask = MASK_16;
      LEN_32: mask = MASK_32;
      default: mask = MASK_32;
    endcase
  end

  assign startAddr = {cmdWord_q[CA_ROW_HI:CA_ROW_LO], cmdWord_q[CA_COL_HI:0]};
  assign maskWide = ADDR_W'(mask_q);
  assign wrapNext = (addr_q & ~maskWide) | ((addr_q + ADDR_W'(1)) & maskWide);
  assign lastWrap = (wrapCnt_q == mask_q);
  assign fifoInValid = (state_q == ST_RUN) && csLow;
  assign push = fifoInValid && fifoInReady;
  assign busy = (state_q == ST_RUN);

  always_comb
  begin
    case (mode_q)
      MODE_LINEAR: addr_d = addr_q + ADDR_W'(1);
      MODE_LEGACY: addr_d = wrapNext;
      MODE_HYBRID: addr_d = lastWrap ? grpBase_q + maskWide + ADDR_W'(1) : wrapNext;
      default: addr_d = addr_q;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE: state_q <= (newCmd && csLow) ? ST_RUN : ST_IDLE;
        ST_RUN: state_q <= csLow ? ST_RUN : ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Hybrid hands over to linear after its last wrap word
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_q <= MODE_LINEAR;
      addr_q <= '0;
      grpBase_q <= '0;
      wrapCnt_q <= '0;
      mask_q <= MASK_32;
    end
    else if (state_q == ST_IDLE && newCmd && csLow)
    begin
      addr_q <= startAddr;
      grpBase_q <= startAddr & ~ADDR_W'(mask);
      wrapCnt_q <= '0;
      mask_q <= mask;
      if (cmdWord_q[BURST_TYPE_POS])
      begin
        mode_q <= MODE_LINEAR;
      end
      else if (burstConfig_q[HYBRID_POS])
      begin
        mode_q <= MODE_LEGACY;
      end
      else
      begin
        mode_q <= MODE_HYBRID;
      end
    end
    else if (push)
    begin
      addr_q <= addr_d;
      wrapCnt_q <= wrapCnt_q + OFS_W'(1);
      if (mode_q == MODE_HYBRID && lastWrap)
      begin
        mode_q <= MODE_LINEAR;
      end
    end
  end

  // Chip select high flushes, so a cut frame drops unread addresses
  sync_fifo #(
    .WIDTH(ADDR_W),
    .DEPTH(FIFO_DEPTH)
  ) addrFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(!csLow),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(addr_q),
    .outValid(arrayValid),
    .outReady(arrayReady),
    .outData(arrayAddr)
  );

  sequence s_push_wrap;
    push && mode_q != MODE_LINEAR && !(mode_q == MODE_HYBRID && lastWrap);
  endsequence

  sequence s_push_last;
    push && mode_q == MODE_HYBRID && lastWrap;
  endsequence

  a_wrap_stays_group: assert property (@(posedge ref_clk) disable iff (rst)
    s_push_wrap |=> (addr_q & ~maskWide) == $past(grpBase_q)
      && (addr_q & maskWide) == (($past(addr_q) + ADDR_W'(1)) & maskWide))
    else $error("wrap left its group");

  a_hybrid_next_group: assert property (@(posedge ref_clk) disable iff (rst)
    s_push_last |=> addr_q == $past(grpBase_q) + maskWide + ADDR_W'(1) && mode_q == MODE_LINEAR)
    else $error("hybrid did not jump to next group");

  a_linear_step_up: assert property (@(posedge ref_clk) disable iff (rst)
    push && mode_q == MODE_LINEAR |=> addr_q == $past(addr_q) + ADDR_W'(1))
    else $error("linear step wrong");

  a_cs_high_stops: assert property (@(posedge ref_clk) disable iff (rst)
    busy && !csLow |=> !busy ##1 !arrayValid)
    else $error("burst ran past chip select high");

  a_hybrid_mode_pick: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_IDLE && newCmd && csLow && !cmdWord_q[BURST_TYPE_POS] && !burstConfig_q[HYBRID_POS]
      |=> mode_q == MODE_HYBRID)
    else $error("hybrid not selected");

  a_config_reset_val: assert property (@(posedge ref_clk) rst |=> burstConfig_q == CFG_RESET)
    else $error("config reset value wrong");

  a_legacy_no_linear: assert property (@(posedge ref_clk) disable iff (rst)
    mode_q == MODE_LEGACY && busy ##1 busy |-> mode_q == MODE_LEGACY)
    else $error("legacy wrap went linear");

  a_group_size_map: assert property (@(posedge ref_clk) disable iff (rst)
    (burstConfig_q[1:0] == LEN_128 |-> mask == 6'h3f) and (burstConfig_q[1:0] == LEN_64 |-> mask == 6'h1f)
      and (burstConfig_q[1:0] == LEN_16 |-> mask == 6'h07) and (burstConfig_q[1:0] == LEN_32 |-> mask == 6'h0f))
    else $error("group size wrong");

  a_linear_type_pick: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_IDLE && newCmd && csLow && cmdWord_q[BURST_TYPE_POS] |=> mode_q == MODE_LINEAR
      && addr_q == $past(startAddr))
    else $error("linear burst not selected");

  a_start_loads_addr: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_IDLE && newCmd && csLow |=> busy && addr_q == $past(startAddr) && wrapCnt_q == '0)
    else $error("burst did not start at the start word");

  a_config_held_busy: assert property (@(posedge ref_clk) disable iff (rst)
    busy |=> burstConfig_q == $past(burstConfig_q))
    else $error("config changed during a burst");

  a_legacy_wraps_top: assert property (@(posedge ref_clk) disable iff (rst)
    push && mode_q == MODE_LEGACY && (addr_q & maskWide) == maskWide |=> addr_q == $past(grpBase_q))
    else $error("legacy wrap did not return to group base");
endmodule : wrap_hybrid_burst_sequencer

// file: tb/host_link_model.sv
`timescale 1ns/1ps

module host_link_model (
  output logic linkClk,
  output logic csN,
  output logic caStrobe,
  output logic [wrap_hybrid_burst_pkg::CA_W-1:0] commandAddressWord
);
  import wrap_hybrid_burst_pkg::*;
  logic clkRun = 1'b1;
  initial
  begin
    linkClk = 1'b0;
    csN = 1'b1;
    caStrobe = 1'b0;
    commandAddressWord = '0;
  end
  // Clock runs from start-up; after each frame it stands low until the next startFrame
  always #32 linkClk = clkRun ? ~linkClk : 1'b0;
  task automatic startFrame(input logic [CA_W-1:0] ca);
    clkRun = 1'b1;
    repeat (3) @(posedge linkClk);
    #1;
    csN = 1'b0;
    caStrobe = 1'b1;
    commandAddressWord = ca;
    @(posedge linkClk);
    #1;
    caStrobe = 1'b0;
    commandAddressWord = ~ca;
  endtask : startFrame
  task automatic endFrame;
    @(posedge linkClk);
    #1;
    csN = 1'b1;
    repeat (3) @(posedge linkClk);
    #1;
    clkRun = 1'b0;
  endtask : endFrame
endmodule : host_link_model

// file: tb/tb_wrap_hybrid_burst_sequencer.sv
`timescale 1ns/1ps

module tb_wrap_hybrid_burst_sequencer;
  import wrap_hybrid_burst_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic linkClk, csN, caStrobe, busy, arrayValid;
  logic cfgWrite = 1'b0;
  logic arrayReady = 1'b0;
  logic [CA_W-1:0] commandAddressWord;
  logic [CFG_W-1:0] cfgData = '0;
  logic [CFG_W-1:0] burstConfig;
  logic [ADDR_W-1:0] arrayAddr;
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  host_link_model host (.linkClk(linkClk), .csN(csN), .caStrobe(caStrobe),
    .commandAddressWord(commandAddressWord));
  wrap_hybrid_burst_sequencer dut (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .csN(csN),
    .caStrobe(caStrobe), .commandAddressWord(commandAddressWord), .cfgWrite(cfgWrite),
    .cfgData(cfgData), .burstConfig(burstConfig), .busy(busy), .arrayValid(arrayValid),
    .arrayReady(arrayReady), .arrayAddr(arrayAddr));
  function automatic logic [31:0] expAddr(input logic [2:0] cfg, input logic bt, input logic [31:0] s, input int i);
    logic [31:0] g;
    logic [31:0] base;
    g = (cfg[1:0] == 2'h0) ? 32'h40 : (cfg[1:0] == 2'h1) ? 32'h20 : (cfg[1:0] == 2'h2) ? 32'h8 : 32'h10;
    base = s & ~(g - 32'h1);
    if (bt)
      return s + 32'(i);
    if (!cfg[2] && 32'(i) >= g)
      return base + 32'(i);
    return base | ((s + 32'(i)) & (g - 32'h1));
  endfunction : expAddr
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    if (errors == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Configure, run one frame, pop n words, close the frame
  task automatic runBurst(input logic [2:0] cfg, input logic bt, input logic [31:0] s, input int n, input int stall);
    int i;
    int k;
    i = 0;
    k = 0;
    @(posedge ref_clk);
    #1;
    cfgWrite = 1'b1;
    cfgData = cfg;
    @(posedge ref_clk);
    #1;
    cfgWrite = 1'b0;
    @(posedge ref_clk);
    check("burstConfig", 32'(cfg), 32'(burstConfig));
    host.startFrame({2'h0, bt, s[31:3], 13'h0, s[2:0]});
    repeat (stall) @(posedge ref_clk);
    if (stall > 0)
      check("fullValid", 32'h1, 32'(arrayValid));
    @(posedge ref_clk);
    #1;
    arrayReady = 1'b1;
    while (i < n && k < 1000)
    begin
      @(negedge ref_clk);
      k++;
      if (arrayValid === 1'b1)
      begin
        check("arrayAddr", expAddr(cfg, bt, s, i), arrayAddr);
        i++;
      end
    end
    check("wordCount", 32'(n), 32'(i));
    @(posedge ref_clk);
    #1;
    arrayReady = 1'b0;
    host.endFrame();
    k = 0;
    while (busy !== 1'b0 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    check("busy", 32'h0, 32'(busy));
    check("flushValid", 32'h0, 32'(arrayValid));
  endtask : runBurst
  task automatic scenReset;
    check("resetConfig", 32'h7, 32'(burstConfig));
    check("resetBusy", 32'h0, 32'(busy));
  endtask : scenReset
  task automatic scenHybrid;
    runBurst(3'h0, 1'b0, 32'h103, 74, 0);
    runBurst(3'h1, 1'b0, 32'h22e, 44, 0);
    runBurst(3'h2, 1'b0, 32'h0c, 20, 12);
    runBurst(3'h3, 1'b0, 32'h1e, 26, 0);
  endtask : scenHybrid
  task automatic scenLegacy;
    runBurst(3'h4, 1'b0, 32'h43, 80, 0);
    runBurst(3'h5, 1'b0, 32'h2e, 70, 0);
    runBurst(3'h6, 1'b0, 32'h0c, 20, 0);
    runBurst(3'h7, 1'b0, 32'h1a, 36, 10);
  endtask : scenLegacy
  task automatic scenLinear;
    runBurst(3'h0, 1'b1, 32'h3d, 20, 0);
    runBurst(3'h6, 1'b1, 32'h07, 12, 0);
  endtask : scenLinear
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    // Long enough for the link side to see reset too
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    scenReset();
    scenHybrid();
    scenLegacy();
    scenLinear();
    wrap_up();
  end
endmodule : tb_wrap_hybrid_burst_sequencer
